// file: shared/mcro_map.vh
`ifndef MCRO_MAP_VH
`define MCRO_MAP_VH

// Register indices; byte address is index times four
`define MCRO_IDX_OPCTL2     6'h08
`define MCRO_IDX_HCLK       6'h0A
`define MCRO_IDX_STAT       6'h0C
`define MCRO_ADDR_OPCTL2    {`MCRO_IDX_OPCTL2, 2'b00}
`define MCRO_ADDR_HCLK      {`MCRO_IDX_HCLK, 2'b00}
`define MCRO_ADDR_STAT      {`MCRO_IDX_STAT, 2'b00}

// Host clock control fields, plus the soft reset bit of register 08h
`define MCRO_HCLK_RST       6'h06
`define MCRO_SEL_MSB        2
`define MCRO_SEL_LSB        0
`define MCRO_LFC_BIT        3
`define MCRO_TAIL_MSB       5
`define MCRO_TAIL_LSB       4
`define MCRO_SWRST_BIT      7

// Divide select codes; the logic tests all but MCRO_SEL_1M by name
`define MCRO_SEL_30M        3'h0
`define MCRO_SEL_15M        3'h1
`define MCRO_SEL_10M        3'h2
`define MCRO_SEL_4M         3'h3
`define MCRO_SEL_3M         3'h4
`define MCRO_SEL_2M         3'h5
`define MCRO_SEL_1M         3'h6
`define MCRO_SEL_LF         3'h7

// Host clock periods, counted in source edges (two per source cycle)
`define MCRO_PER_30M        6'h02
`define MCRO_PER_15M        6'h04
`define MCRO_PER_10M        6'h06
`define MCRO_PER_4M         6'h0F
`define MCRO_PER_3M         6'h14
`define MCRO_PER_2M         6'h1E
`define MCRO_PER_1M         6'h3C
`define MCRO_PER_LF         6'h02

// Tail codes and lengths in host clock cycles
`define MCRO_TAIL_NONE      2'h0
`define MCRO_TAIL_128       10'h080
`define MCRO_TAIL_256       10'h100
`define MCRO_TAIL_512       10'h200

// Timing
`define MCRO_CLK_MHZ        100
`define MCRO_T_SWRST_US     50
`define MCRO_T_GLITCH_US    16000

`endif

// file: verilog/mcro_clk_div.v
`timescale 1ns/1ps
`include "mcro_map.vh"

module mcro_clk_div (
  input  wire       i_mclk,
  input  wire       i_rst,
  input  wire       i_xtal_edge,
  input  wire       i_lf_edge,
  input  wire [2:0] i_sel,
  input  wire       i_lf_sel,
  input  wire       i_run,
  output reg        o_clk,
  output reg        o_wrap,
  output reg        o_cur_lf,
  output reg        o_halted
);

  reg  [5:0] cnt_reg;
  reg  [5:0] per_reg;
  reg  [5:0] hi_reg;
  wire       tick;
  wire [5:0] per_new;

  // Period of the host clock in source edges
  function [5:0] period;
    input [2:0] sel;
    input       lf;
    begin
      if (lf) begin
        period = `MCRO_PER_LF;
      end else begin
        case (sel)
          `MCRO_SEL_30M: period = `MCRO_PER_30M;
          `MCRO_SEL_15M: period = `MCRO_PER_15M;
          `MCRO_SEL_10M: period = `MCRO_PER_10M;
          `MCRO_SEL_4M:  period = `MCRO_PER_4M;
          `MCRO_SEL_3M:  period = `MCRO_PER_3M;
          `MCRO_SEL_2M:  period = `MCRO_PER_2M;
          default:       period = `MCRO_PER_1M;
        endcase
      end
    end
  endfunction

  assign tick    = o_cur_lf ? i_lf_edge : i_xtal_edge;
  assign per_new = period(i_sel, i_lf_sel);

  // New source, ratio or stop only at a period boundary, so no phase is cut short
  always @(posedge i_mclk) begin
    o_wrap <= 1'b0;
    if (i_rst) begin
      cnt_reg  <= `MCRO_PER_1M - 6'h01; // First tick after reset starts a whole high phase
      per_reg  <= `MCRO_PER_1M;
      hi_reg   <= `MCRO_PER_1M >> 1;
      o_cur_lf <= 1'b0;
      o_halted <= 1'b0;
      o_clk    <= 1'b0;
    end else if (o_halted) begin
      // Output is low and idle; new settings may load at once
      per_reg  <= per_new;
      hi_reg   <= (per_new + 6'h01) >> 1;
      o_cur_lf <= i_lf_sel;
      cnt_reg  <= per_new - 6'h01;
      o_halted <= ~i_run;
    end else if (tick) begin
      if (cnt_reg == per_reg - 6'h01) begin
        o_wrap   <= 1'b1;
        per_reg  <= per_new;
        hi_reg   <= (per_new + 6'h01) >> 1; // Odd periods get the longer high half
        o_cur_lf <= i_lf_sel;
        o_halted <= ~i_run;
        if (o_cur_lf != i_lf_sel) begin
          // Source swap: edges of the two sources are unrelated, so stay low until the new one ticks
          cnt_reg <= per_new - 6'h01;
          o_clk   <= 1'b0;
        end else begin
          cnt_reg <= 6'h00;
          o_clk   <= i_run;
        end
      end else begin
        cnt_reg <= cnt_reg + 6'h01;
        o_clk   <= (cnt_reg + 6'h01) < hi_reg;
      end
    end
  end

endmodule

// file: verilog/mcro_top.v
`timescale 1ns/1ps
`include "mcro_map.vh"

// How it works
// - Eight host clock rates chosen by three-bit divide select, 30 MHz to 32.768 kHz.
// - All rates but 4 MHz and 32.768 kHz are integer divisions of the crystal.
// - After reset the host clock runs at 1 MHz, control default 06h.
// - Slow clock enable set: sleep supplies 32.768 kHz, ignoring divide select.
// - Idle, transmit and receive output the divide-selected rate.
// - Crystal oscillator stops during sleep.
// - Slow clock enable clear: host clock stops in sleep after any tail.
// - Tail field gives 0, 128, 256 or 512 extra cycles before stopping.
// - Pending interrupt keeps the host clock running in every mode.
// - Mode change waits until the host has read the pending interrupt.
// - Sleep with interrupt outstanding keeps the crystal running until cleared.
// - Any internal reset returns all registers to default values.
// - Reset appears on the reset pin and inverted on its twin.
// - Soft reset via register 08h holds internal reset for the soft pulse time.
// - Power-on and shutdown release give a long internal reset pulse.
// - Control register 0Ah: tail 5:4, slow enable 3, divide select 2:0.
module mcro_top #(
  parameter [31:0] P_SWRST_CYC  = `MCRO_T_SWRST_US * `MCRO_CLK_MHZ,
  parameter [31:0] P_GLITCH_CYC = `MCRO_T_GLITCH_US * `MCRO_CLK_MHZ
) (
  input  wire        i_mclk,
  input  wire        i_sys_rst,
  input  wire        i_shutdown_pin,
  input  wire        i_xtal_edge,
  input  wire        i_lf_edge,
  input  wire        i_sleep_req,
  input  wire        i_irq_pending,
  input  wire [7:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  output wire        o_clock_output_pin,
  output reg         o_xtal_en,
  output reg         o_sleep_active,
  output reg         o_int_rst,
  output reg         o_rst_pin,
  output reg         o_rst_pin_n
);

  localparam [1:0] ST_RUN   = 2'b00;
  localparam [1:0] ST_TAIL  = 2'b01;
  localparam [1:0] ST_SWAP  = 2'b10;
  localparam [1:0] ST_SLEEP = 2'b11;

  localparam [23:0] SWRST_CYC  = P_SWRST_CYC[23:0];
  localparam [23:0] GLITCH_CYC = P_GLITCH_CYC[23:0];

  reg  [5:0]  hclk_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [9:0]  tail_cnt_reg;
  reg  [9:0]  tail_cnt_next;
  reg  [23:0] rst_cnt_reg;
  reg  [31:0] rd_mux;
  reg         run_req;
  reg         lf_req;
  wire        rst_all;
  wire        bus_req;
  wire        bus_wr;
  wire        soft_rst;
  wire [2:0]  sel;
  wire        lfc;
  wire [1:0]  tail;
  wire [9:0]  tail_len;
  wire        div_wrap;
  wire        div_lf;
  wire        div_halted;
  wire        hold;

  // Decode of the host clock control fields
  assign sel  = hclk_reg[`MCRO_SEL_MSB:`MCRO_SEL_LSB];
  assign lfc  = hclk_reg[`MCRO_LFC_BIT];
  assign tail = hclk_reg[`MCRO_TAIL_MSB:`MCRO_TAIL_LSB];

  // Tail length in host clock cycles
  function [9:0] tail_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h1:    tail_cycles = `MCRO_TAIL_128;
        2'h2:    tail_cycles = `MCRO_TAIL_256;
        2'h3:    tail_cycles = `MCRO_TAIL_512;
        default: tail_cycles = 10'h000;
      endcase
    end
  endfunction

  assign tail_len = tail_cycles(tail);

  // Bus slave stays alive through internal reset so software can poll status
  assign rst_all  = i_sys_rst | o_int_rst;
  assign bus_req  = i_avs_read | i_avs_write;
  assign bus_wr   = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  assign soft_rst = bus_wr & (i_avs_address == `MCRO_ADDR_OPCTL2) & i_avs_writedata[`MCRO_SWRST_BIT];

  // Interrupt pending or sleep withdrawn both pull the sequencer back to run
  assign hold = i_irq_pending | ~i_sleep_req;

  // Internal reset sequencer
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_int_rst   <= 1'b1;
      rst_cnt_reg <= GLITCH_CYC;
    end else if (i_shutdown_pin) begin
      o_int_rst   <= 1'b1;
      rst_cnt_reg <= GLITCH_CYC;
    end else if (soft_rst) begin
      o_int_rst   <= 1'b1;
      rst_cnt_reg <= SWRST_CYC;
    end else if (rst_cnt_reg != 24'h00_0000) begin
      rst_cnt_reg <= rst_cnt_reg - 24'h00_0001;
      o_int_rst   <= (rst_cnt_reg != 24'h00_0001);
    end else begin
      o_int_rst <= 1'b0;
    end
  end

  // Reset presented to the host on both pins
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rst_pin   <= 1'b1;
      o_rst_pin_n <= 1'b0;
    end else begin
      o_rst_pin   <= o_int_rst;
      o_rst_pin_n <= ~o_int_rst;
    end
  end

  // Host clock control register
  always @(posedge i_mclk) begin
    if (rst_all) begin
      hclk_reg <= `MCRO_HCLK_RST;
    end else if (bus_wr && i_avs_address == `MCRO_ADDR_HCLK) begin
      hclk_reg <= i_avs_writedata[5:0];
    end
  end

  // Read data selection; unmapped addresses read zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      `MCRO_ADDR_HCLK: begin
        rd_mux[5:0] = hclk_reg;
      end
      `MCRO_ADDR_STAT: begin
        rd_mux[1:0] = state_reg;
        rd_mux[2]   = o_xtal_en;
        rd_mux[3]   = div_lf;
        rd_mux[4]   = div_halted;
        rd_mux[5]   = o_int_rst;
        rd_mux[6]   = o_sleep_active;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // One wait cycle per request; read data is captured one edge before the write lands
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
      if (bus_req && o_avs_waitrequest) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  // Sleep sequencer: next state and divider requests
  always @* begin
    state_next    = state_reg;
    tail_cnt_next = tail_cnt_reg;
    run_req       = 1'b1;
    lf_req        = (sel == `MCRO_SEL_LF);
    case (state_reg)
      ST_RUN: begin
        // Selected rate in idle, transmit and receive
        if (!hold) begin
          if (lfc) begin
            state_next = ST_SWAP;
          end else if (tail != `MCRO_TAIL_NONE) begin
            state_next    = ST_TAIL;
            tail_cnt_next = 10'h000;
          end else begin
            state_next = ST_SWAP;
          end
        end
      end
      ST_TAIL: begin
        // Stop request rides the wrap that ends the last tail cycle
        run_req = (tail_cnt_reg != tail_len - 10'h001);
        if (hold) begin
          state_next = ST_RUN;
        end else if (div_wrap) begin
          if (!run_req) begin
            state_next = ST_SWAP;
          end else begin
            tail_cnt_next = tail_cnt_reg + 10'h001;
          end
        end
      end
      ST_SWAP: begin
        run_req = lfc;
        lf_req  = lfc | (sel == `MCRO_SEL_LF);
        if (hold) begin
          state_next = ST_RUN;
        end else if (lfc ? div_lf : div_halted) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        run_req = lfc;
        lf_req  = lfc | (sel == `MCRO_SEL_LF);
        if (hold) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // Sequencer registers and crystal enable
  always @(posedge i_mclk) begin
    if (rst_all) begin
      state_reg      <= ST_RUN;
      tail_cnt_reg   <= 10'h000;
      o_xtal_en      <= 1'b1;
      o_sleep_active <= 1'b0;
    end else begin
      state_reg    <= state_next;
      tail_cnt_reg <= tail_cnt_next;
      // Crystal only stops once the host clock has left it
      o_xtal_en      <= (state_next != ST_SLEEP);
      o_sleep_active <= (state_next == ST_SLEEP);
    end
  end

  // Host clock generator; its output flop drives the pin directly
  mcro_clk_div u_div (
    .i_mclk      (i_mclk),
    .i_rst       (rst_all),
    .i_xtal_edge (i_xtal_edge & o_xtal_en),
    .i_lf_edge   (i_lf_edge),
    .i_sel       (sel),
    .i_lf_sel    (lf_req),
    .i_run       (run_req),
    .o_clk       (o_clock_output_pin),
    .o_wrap      (div_wrap),
    .o_cur_lf    (div_lf),
    .o_halted    (div_halted)
  );

endmodule

// file: verif/mcro_chk_sva.sv
`timescale 1ns/1ps
module mcro_chk #(
  parameter [31:0] P_SWRST_CYC = 32'h0000_0014
) (
  input wire        i_mclk,
  input wire        i_sys_rst,
  input wire        i_shutdown_pin,
  input wire        i_sleep_req,
  input wire        i_irq_pending,
  input wire [7:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0]  i_avs_byteenable,
  input wire        o_avs_waitrequest,
  input wire        o_clock_output_pin,
  input wire        o_xtal_en,
  input wire        o_sleep_active,
  input wire        o_int_rst,
  input wire        o_rst_pin,
  input wire        o_rst_pin_n
);
  reg [31:0] rcnt_reg;
  // Length of the running internal reset pulse
  always @(posedge i_mclk)
    rcnt_reg <= (i_sys_rst || !o_int_rst) ? 32'h0000_0000 : rcnt_reg + 32'h0000_0001;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  property p_pins; o_rst_pin != o_rst_pin_n; endproperty
  a_pins: assert property (p_pins) else $error("reset pins not complementary");
  property p_pin2; o_int_rst |-> ##[0:1] o_rst_pin; endproperty
  a_pin2: assert property (p_pin2) else $error("reset pin does not follow reset");
  property p_swrst;
    i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h20 && i_avs_writedata[7] && i_avs_byteenable[0]
      |-> ##[1:2] o_int_rst;
  endproperty
  a_swrst: assert property (p_swrst) else $error("soft reset write gave no reset");
  property p_len; $fell(o_int_rst) |-> rcnt_reg >= P_SWRST_CYC; endproperty
  a_len: assert property (p_len) else $error("internal reset too short");
  property p_shut; i_shutdown_pin |-> ##[1:2] o_int_rst; endproperty
  a_shut: assert property (p_shut) else $error("shutdown without reset");
  property p_irq; i_irq_pending |-> ##[1:2] o_xtal_en; endproperty
  a_irq: assert property (p_irq) else $error("crystal off while interrupt pending");
  property p_run; i_irq_pending || !i_sleep_req |-> ##[1:2] !o_sleep_active; endproperty
  a_run: assert property (p_run) else $error("sleep held against run");
  property p_sleep; $rose(o_sleep_active) |-> ##[0:1] !o_xtal_en; endproperty
  a_sleep: assert property (p_sleep) else $error("crystal left on in sleep");
  property p_phase;
    $changed(o_clock_output_pin) |=> $stable(o_clock_output_pin) || o_int_rst;
  endproperty
  a_phase: assert property (p_phase) else $error("host clock phase truncated");
  property p_ack; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered");
  c_swrst: cover property ($rose(o_int_rst));
  c_sleep: cover property ($rose(o_sleep_active));
  c_slow: cover property (o_sleep_active && $changed(o_clock_output_pin));
endmodule

// file: verif/mcro_host.sv
`timescale 1ns/1ps
module mcro_host (
  input  wire         i_mclk,
  input  wire         i_hclk,
  input  wire         i_rst_pin,
  output logic [15:0] o_per,
  output logic [15:0] o_edges
);
  logic        hclk_q;
  logic [15:0] cyc;
  // Host times its clock rising edge to rising edge
  always @(posedge i_mclk) begin
    hclk_q <= i_hclk;
    cyc    <= (i_hclk && !hclk_q) ? 16'h0001 : cyc + 16'h0001;
    if (i_hclk && !hclk_q) begin
      o_per   <= cyc;
      o_edges <= o_edges + 16'h0001;
    end
    if (i_rst_pin)
      o_edges <= 16'h0000; // Host held in reset by the pin
  end
endmodule

// file: verif/mcu_clock_and_reset_output_bench.sv
`timescale 1ns/1ps
module mcu_clock_and_reset_output_bench;
  logic        mclk = 1'b0, rst = 1'b1, shdn = 1'b0, xe = 1'b0, le = 1'b0;
  logic        slp = 1'b0, irq = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdata, q;
  logic [2:0]  lc = 3'h0;
  logic        wrq, hclk, xen, sact, irst, rpin, rpinn;
  logic [15:0] per, edges;
  int          n_errors = 0, compares = 0;
  int          pers [8] = '{4, 8, 12, 30, 40, 60, 120, 16};
  int          tl [4] = '{0, 128, 256, 512};
  mcro_top #(.P_SWRST_CYC(32'h0000_0014), .P_GLITCH_CYC(32'h0000_0032)) DUT (
    .i_mclk(mclk), .i_sys_rst(rst), .i_shutdown_pin(shdn), .i_xtal_edge(xe), .i_lf_edge(le),
    .i_sleep_req(slp), .i_irq_pending(irq), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'h1), .o_avs_readdata(rdata), .o_avs_waitrequest(wrq),
    .o_clock_output_pin(hclk), .o_xtal_en(xen), .o_sleep_active(sact), .o_int_rst(irst),
    .o_rst_pin(rpin), .o_rst_pin_n(rpinn));
  mcro_host u_host (.i_mclk(mclk), .i_hclk(hclk), .i_rst_pin(rpin), .o_per(per), .o_edges(edges));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // Crystal edge every 2 cycles, slow source edge every 8
  always @(posedge mclk) begin
    xe <= ~xe;
    lc <= lc + 3'h1;
    le <= (lc == 3'h7);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h00_0000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wrq !== 1'b0 && n < 100);
    if (wrq !== 1'b0)
      n_errors++; // Bus never answered
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_sleep(input logic v);
    int n;
    n = 0;
    while (sact !== v && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk(sact, v, "sleep state");
  endtask
  task automatic rst_len(input int exp);
    int n;
    n = 0;
    while (irst === 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    chk(n >= exp - 2 && n <= exp + 2, 1'b1, "reset length");
  endtask
  task automatic t_reset;
    bus(1'b0, 8'h28, 8'h00);
    chk(q, 32'h0000_0006, "control default");
    repeat (300) @(posedge mclk);
    chk(per, 120, "default period");
  endtask
  task automatic t_rates;
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, 8'h28, s[7:0]);
      repeat (300) @(posedge mclk);
      chk(per, pers[s], "period");
    end
  endtask
  task automatic t_lf;
    bus(1'b1, 8'h28, 8'h08);
    slp <= 1'b1;
    wait_sleep(1'b1);
    repeat (2) @(posedge mclk);
    chk(xen, 1'b0, "crystal in sleep");
    bus(1'b0, 8'h30, 8'h00);
    chk(q, 32'h0000_004B, "status in slow sleep");
    repeat (100) @(posedge mclk);
    chk(per, 16, "slow clock in sleep");
    slp <= 1'b0;
    wait_sleep(1'b0);
  endtask
  task automatic t_tail;
    logic [15:0] e0;
    for (int t = 0; t < 4; t++) begin
      bus(1'b1, 8'h28, {2'b00, t[1:0], 4'h0});
      repeat (20) @(posedge mclk);
      e0 = edges;
      slp <= 1'b1;
      wait_sleep(1'b1);
      e0 = edges - e0;
      chk(e0 + 1 >= tl[t] && e0 <= tl[t] + 1, 1'b1, "tail cycles");
      e0 = edges;
      repeat (100) @(posedge mclk);
      chk(edges - e0, 0, "clock stopped");
      chk(hclk, 1'b0, "halt level");
      slp <= 1'b0;
      wait_sleep(1'b0);
    end
  endtask
  task automatic t_irq;
    logic [15:0] e0;
    bus(1'b1, 8'h28, 8'h00);
    irq <= 1'b1;
    slp <= 1'b1;
    e0 = edges;
    repeat (300) @(posedge mclk);
    chk(sact, 1'b0, "sleep deferred");
    chk(xen, 1'b1, "crystal kept on");
    chk(edges - e0 > 16'h0040, 1'b1, "clock running");
    irq <= 1'b0; // Host has now read the interrupt
    wait_sleep(1'b1);
    slp <= 1'b0;
    wait_sleep(1'b0);
  endtask
  task automatic t_rst;
    bus(1'b1, 8'h28, 8'h3D);
    bus(1'b0, 8'h28, 8'h00);
    chk(q, 32'h0000_003D, "control fields");
    bus(1'b0, 8'h3C, 8'h00);
    chk(q, 32'h0000_0000, "unmapped read");
    bus(1'b1, 8'h20, 8'h80);
    repeat (2) @(posedge mclk);
    rst_len(20);
    bus(1'b0, 8'h28, 8'h00);
    chk(q, 32'h0000_0006, "default after reset");
    shdn <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(rpin, 1'b1, "reset pin active");
    shdn <= 1'b0;
    rst_len(50);
    repeat (2) @(posedge mclk);
    chk(rpinn, 1'b1, "inverted pin released");
    chk(rpin, 1'b0, "reset pin released");
  endtask
  task automatic close_out;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (80) @(posedge mclk);
    t_reset;
    t_rates;
    t_lf;
    t_tail;
    t_irq;
    t_rst;
    close_out;
  end
  // Hang guard, well above the whole run
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    close_out;
  end
endmodule
bind mcro_top mcro_chk #(.P_SWRST_CYC(P_SWRST_CYC)) u_chk (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_shutdown_pin(i_shutdown_pin), .i_sleep_req(i_sleep_req),
  .i_irq_pending(i_irq_pending), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_waitrequest(o_avs_waitrequest), .o_clock_output_pin(o_clock_output_pin), .o_xtal_en(o_xtal_en),
  .o_sleep_active(o_sleep_active), .o_int_rst(o_int_rst), .o_rst_pin(o_rst_pin), .o_rst_pin_n(o_rst_pin_n));
